// >>> hw/uvp_top.sv
// Four-stage undervoltage protection with APB register access.
`timescale 1ns/10ps
module uvp_top #(
  // Refresh period in clock cycles; a bench may shorten it to run fast.
  parameter int TICK_CYC = uvp_pkg::REFRESH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Phase-phase magnitudes L12, L23, L31.
  input wire logic [uvp_pkg::MW-1:0] mag_pp0,
  input wire logic [uvp_pkg::MW-1:0] mag_pp1,
  input wire logic [uvp_pkg::MW-1:0] mag_pp2,
  // Phase-earth magnitudes L1, L2, L3.
  input wire logic [uvp_pkg::MW-1:0] mag_pe0,
  input wire logic [uvp_pkg::MW-1:0] mag_pe1,
  input wire logic [uvp_pkg::MW-1:0] mag_pe2,
  // Auxiliary channels three and four.
  input wire logic [uvp_pkg::MW-1:0] third_voltage_input,
  input wire logic [uvp_pkg::MW-1:0] fourth_voltage_input,
  // External block from the blocking matrix, one per stage (async pin).
  input wire logic [3:0] ext_block,
  output logic [3:0] start_o,
  output logic [3:0] trip_o,
  output logic [3:0] blocked_o
);
  // Global control word.
  logic [2:0] glob_q;
  // Per-stage control and level words (level: pick-up low, block high).
  logic [31:0] ctrl_q [4];
  logic [31:0] level_q [4];
  // Sampled magnitudes, refreshed on the fixed time base.
  logic [uvp_pkg::MW-1:0] m_q [8];
  // Refresh timer.
  logic [23:0] tick_cnt_q;
  logic tick;
  // High once the first sample set is latched; stages wait for it.
  logic primed_q;
  // Three-stage synchroniser of the external block pins.
  logic [3:0] eb_s1_q, eb_s2_q, eb_s3_q, eb_q;
  // Stage state.
  logic [3:0] pick_q, lvblk_q, start_q, trip_q, blkd_q;

  // Refresh tick every 5 ms; magnitudes are latched only on it. RQ3
  assign tick = (tick_cnt_q == 24'(TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
    end
  end

  // The sample registers reset to zero, which reads as a dead network.
  // Evaluating that would raise start on stages at the first tick, so
  // the stages sit out the tick that brings in the first sample set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_q <= 1'b0;
    end else if (tick) begin
      primed_q <= 1'b1;
    end
  end

  // Magnitude sampling; holding values between ticks keeps decisions
  // stable across one measurement period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) m_q[i] <= 16'h0000;
    end else if (tick) begin
      m_q[0] <= mag_pp0;
      m_q[1] <= mag_pp1;
      m_q[2] <= mag_pp2;
      m_q[3] <= mag_pe0;
      m_q[4] <= mag_pe1;
      m_q[5] <= mag_pe2;
      m_q[6] <= third_voltage_input;
      m_q[7] <= fourth_voltage_input;
    end
  end

  // External block synchroniser; a change counts when stages 2 and 3 agree.
  // Only the second flop reads the first, which keeps a metastable first
  // flop from ever reaching the stage logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eb_s1_q <= 4'h0;
      eb_s2_q <= 4'h0;
      eb_s3_q <= 4'h0;
      eb_q <= 4'h0;
    end else begin
      eb_s1_q <= ext_block;
      eb_s2_q <= eb_s1_q;
      eb_s3_q <= eb_s2_q;
      for (int i = 0; i < 4; i++) begin
        if (eb_s2_q[i] == eb_s3_q[i]) eb_q[i] <= eb_s3_q[i];
      end
    end
  end

  // APB decode: stage index and word within the stage window.
  wire logic acc = psel && penable;
  // End of the stage window, one stride past the last stage.
  wire logic [11:0] stg_end = uvp_pkg::STG_BASE +
                              12'(uvp_pkg::NSTAGE) * uvp_pkg::STG_STRIDE;
  wire logic in_stg = (paddr >= uvp_pkg::STG_BASE) &&
                      (paddr < stg_end) && (paddr[1:0] == 2'b00);
  wire logic [11:0] stg_rel = paddr - uvp_pkg::STG_BASE;
  wire logic [1:0] sidx = stg_rel[5:4];
  wire logic [3:0] sword = stg_rel[3:0];
  wire logic hit_glob = (paddr == uvp_pkg::GLOBAL_OFS);
  wire logic hit_chan = (paddr == uvp_pkg::CHAN_OFS);
  wire logic hit_ctrl = in_stg && (sword == uvp_pkg::STG_CTRL);
  wire logic hit_lvl = in_stg && (sword == uvp_pkg::STG_LEVEL);
  wire logic hit_stat = in_stg && (sword == uvp_pkg::STG_STAT);
  wire logic mapped = hit_glob || hit_chan || hit_ctrl || hit_lvl || hit_stat;
  wire logic allow_mode = glob_q[uvp_pkg::G_ALLOW_MODE];
  wire logic force_en = glob_q[uvp_pkg::G_FORCE_EN];
  wire logic two_line = glob_q[uvp_pkg::G_TWO_LINE];

  // Always ready in one access cycle; unmapped addresses get an error.
  // A write to a read-only word is dropped quietly, with no error.
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Register writes. The mode field only takes a write while individual
  // mode setting is allowed. RQ7
  // Levels may be rewritten at any time and the stages use them at once,
  // with no restart of the running state. RQ13
  // Mode and force live in their own control word, so reloading the
  // level word for a new setting group never disturbs them. RQ9
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob_q <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        ctrl_q[i] <= 32'h00000000;
        level_q[i] <= {uvp_pkg::BLOCK_RST, uvp_pkg::PICKUP_RST}; // RQ12 RQ14
      end
    end else if (acc && pwrite) begin
      if (hit_glob) glob_q <= pwdata[2:0];
      if (hit_lvl) level_q[sidx] <= pwdata;
      if (hit_ctrl) begin
        ctrl_q[sidx][15:4] <= pwdata[15:4];
        if (allow_mode) ctrl_q[sidx][3:0] <= pwdata[3:0]; // RQ7
      end
    end
  end

  // Read mux; magnitudes of channel 3/4 at CHAN_OFS show sampled state.
  // Read data is combinational, so the bus never needs a wait state.
  always_comb begin
    prdata = 32'h00000000;
    if (hit_glob) prdata = {29'h0, glob_q};
    else if (hit_chan) prdata = {m_q[7], m_q[6]};
    else if (hit_ctrl) prdata = {16'h0000, ctrl_q[sidx][15:0]};
    else if (hit_lvl) prdata = level_q[sidx];
    else if (hit_stat)
      prdata = {26'h0, lvblk_q[sidx], pick_q[sidx], eb_q[sidx],
                blkd_q[sidx], trip_q[sidx], start_q[sidx]};
  end

  // Per-stage evaluation, generated once for each of the four stages. RQ1
  for (genvar s = 0; s < uvp_pkg::NSTAGE; s++) begin : g_stage
    logic [uvp_pkg::MW-1:0] v0, v1, v2, pu, bl;
    logic [1:0] nv;
    logic any_low, all_rel, all_abv, any_blk;
    logic [23:0] rel_lvl;
    uvp_pkg::uvp_sel_t sel;
    uvp_pkg::uvp_mode_t mode;
    uvp_pkg::uvp_force_t frc;
    logic inst;
    logic st_d, tr_d, bk_d, pk_d, lv_d;
    assign pu = level_q[s][15:0]; // RQ10
    assign bl = level_q[s][31:16];
    assign sel = uvp_pkg::uvp_sel_t'(ctrl_q[s][uvp_pkg::C_SEL_LSB +: 2]);
    assign frc = uvp_pkg::uvp_force_t'(ctrl_q[s][uvp_pkg::C_FORCE_LSB +: 2]);
    assign inst = ctrl_q[s][uvp_pkg::C_INSTANT];
    // Release level is 103 percent of pick-up, kept at full width.
    assign rel_lvl = (24'(pu) * 24'(uvp_pkg::HYST_PCT)) / 24'd100; // RQ11

    // Monitored voltage selection and count of valid channels. RQ4
    always_comb begin
      v0 = m_q[0];
      v1 = m_q[1];
      v2 = m_q[2];
      nv = 2'd3;
      mode = uvp_pkg::UVP_MODE_OFF;
      unique case (ctrl_q[s][uvp_pkg::C_MODE_LSB +: 3])
        3'd0: mode = uvp_pkg::UVP_MODE_ON;
        3'd1: mode = uvp_pkg::UVP_MODE_BLOCKED;
        3'd2: mode = uvp_pkg::UVP_MODE_TEST;
        3'd3: mode = uvp_pkg::UVP_MODE_TESTBLK;
        default: mode = uvp_pkg::UVP_MODE_OFF;
      endcase
      unique case (sel)
        uvp_pkg::UVP_SEL_PP: begin
          nv = two_line ? 2'd2 : 2'd3; // RQ5
        end
        uvp_pkg::UVP_SEL_PE: begin
          v0 = m_q[3];
          v1 = m_q[4];
          v2 = m_q[5];
          nv = two_line ? 2'd2 : 2'd3; // RQ5
        end
        uvp_pkg::UVP_SEL_THIRD: begin
          v0 = m_q[6];
          nv = two_line ? 2'd1 : 2'd0; // RQ6
        end
        // Channel four is watched in every connection mode.
        uvp_pkg::UVP_SEL_FOURTH: begin
          v0 = m_q[7];
          nv = 2'd1; // RQ5
        end
      endcase
    end

    // Any valid channel below pick-up starts pick-up. RQ17
    assign any_low = (nv >= 2'd1 && v0 < pu) || (nv >= 2'd2 && v1 < pu) ||
                     (nv == 2'd3 && v2 < pu);
    // All valid channels above the hysteresis level release it. RQ11
    assign all_rel = (nv == 2'd0) || ((24'(v0) > rel_lvl) &&
                     (nv < 2'd2 || 24'(v1) > rel_lvl) &&
                     (nv < 2'd3 || 24'(v2) > rel_lvl));
    // All valid channels above pick-up end the low-voltage latch. RQ16
    assign all_abv = (nv == 2'd0) || ((v0 > pu) && (nv < 2'd2 || v1 > pu) &&
                     (nv < 2'd3 || v2 > pu));
    // Zero block level disables the internal block. RQ14
    assign any_blk = (bl != 16'h0000) && (nv != 2'd0) &&
                     ((v0 < bl) || (nv >= 2'd2 && v1 < bl) ||
                      (nv == 2'd3 && v2 < bl)); // RQ2

    // Next stage state. Only instant timing is built here: trip follows
    // start in the same cycle. Inverse time needs a root/division unit
    // and stays with the software timer, flagged by the instant bit.
    always_comb begin
      pk_d = pick_q[s] ? !all_rel : any_low; // RQ10 RQ11
      lv_d = lvblk_q[s] ? !all_abv : any_blk; // RQ16
      st_d = 1'b0;
      tr_d = 1'b0;
      bk_d = 1'b0;
      // Test mode runs exactly like On; the test flag only matters to the
      // event logic outside this block.
      if (mode != uvp_pkg::UVP_MODE_OFF && pk_d) begin
        if (eb_q[s] || mode == uvp_pkg::UVP_MODE_BLOCKED ||
            mode == uvp_pkg::UVP_MODE_TESTBLK) begin
          bk_d = 1'b1; // RQ18 RQ2
        end else begin
          st_d = 1'b1;
          tr_d = inst && !lv_d; // RQ19 RQ15 RQ20
        end
      end
      // Forcing wins over the measured state but leaves the pick-up and
      // low-voltage latches running, so ending it shows the true state.
      if (force_en) begin
        unique case (frc)
          uvp_pkg::UVP_F_NORMAL: ;
          uvp_pkg::UVP_F_START: begin
            st_d = 1'b1;
            tr_d = 1'b0;
            bk_d = 1'b0;
          end
          uvp_pkg::UVP_F_TRIP: begin
            st_d = 1'b1;
            tr_d = 1'b1;
            bk_d = 1'b0;
          end
          uvp_pkg::UVP_F_BLOCKED: begin
            st_d = 1'b0;
            tr_d = 1'b0;
            bk_d = 1'b1;
          end
        endcase // RQ8
      end
    end

    // Stage state is re-evaluated on each refresh tick after the first, like one cycle
    // of the protection program.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pick_q[s] <= 1'b0;
        lvblk_q[s] <= 1'b0;
        start_q[s] <= 1'b0;
        trip_q[s] <= 1'b0;
        blkd_q[s] <= 1'b0;
      end else if (tick && primed_q) begin
        pick_q[s] <= pk_d;
        lvblk_q[s] <= lv_d;
        start_q[s] <= st_d;
        trip_q[s] <= tr_d;
        blkd_q[s] <= bk_d;
      end
    end
  end

  // Outputs come straight from the stage registers, so they change only
  // on a refresh tick.
  assign start_o = start_q;
  assign trip_o = trip_q;
  assign blocked_o = blkd_q;
endmodule

// >>> hw/uvp_pkg.sv
// Package with constants, register map and types of the undervoltage stages.
// Contract
// (RQ1) Four independent stages with own outputs.
// (RQ2) Internal low-voltage block plus external block.
// (RQ3) Uses six RMS magnitudes refreshed every 5 ms.
// (RQ4) Selector: phase-phase, phase-earth, third, fourth input.
// (RQ5) Two-line mode uses only first two channels.
// (RQ6) Third input monitored only in two-line mode.
// (RQ7) Mode On/Blocked/Test/TestBlocked/Off, gated globally.
// (RQ8) Global forcing overrides status per stage.
// (RQ9) Mode and force ignore setting group changes.
// (RQ10) Common pick-up level, pick-up below it.
// (RQ11) Release only above 103 percent of level.
// (RQ12) Pick-up level in 0.01 percent steps, default 60.
// (RQ13) Setting group change applies without restart.
// (RQ14) Block level default 10 percent, zero disables.
// (RQ15) Trip suppressed while voltage below block level.
// (RQ16) Block latched until all voltages above pick-up.
// (RQ17) Pick-up when any monitored voltage is low.
// (RQ18) External block gives blocked instead of start.
// (RQ19) Instant operation trips together with start.
// (RQ20) Inverse time: dial over one minus ratio power. Not built here: only instant trip, inverse time is left to the software timer.
package uvp_pkg;
  // Number of stages.
  localparam int NSTAGE = 4;
  // Magnitudes are in hundredths of a percent of nominal, 16 bits.
  localparam int MW = 16;
  // Refresh period of magnitudes and its cycle count at 100 MHz.
  localparam int REFRESH_MS = 5;
  localparam int CLK_MHZ = 100;
  localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ;
  // Reset values of pick-up and block levels.
  localparam logic [MW-1:0] PICKUP_RST = 16'h1770;
  localparam logic [MW-1:0] BLOCK_RST = 16'h03E8;
  // Release hysteresis in percent of the pick-up level.
  localparam int HYST_PCT = 103;
  // Register byte offsets: global, then per stage at STG_BASE + 16*n.
  localparam logic [11:0] GLOBAL_OFS = 12'h000;
  localparam logic [11:0] CHAN_OFS = 12'h004;
  localparam logic [11:0] STG_BASE = 12'h010;
  localparam logic [11:0] STG_STRIDE = 12'h010;
  localparam logic [3:0] STG_CTRL = 4'h0;
  localparam logic [3:0] STG_LEVEL = 4'h4;
  localparam logic [3:0] STG_STAT = 4'h8;
  // Global bit positions.
  localparam int G_ALLOW_MODE = 0;
  localparam int G_FORCE_EN = 1;
  localparam int G_TWO_LINE = 2;
  // Control field positions within a stage control word.
  localparam int C_MODE_LSB = 0;
  localparam int C_FORCE_LSB = 4;
  localparam int C_SEL_LSB = 8;
  localparam int C_INSTANT = 12;
  // Measured magnitude selection.
  typedef enum logic [1:0] {
    UVP_SEL_PP, UVP_SEL_PE, UVP_SEL_THIRD, UVP_SEL_FOURTH
  } uvp_sel_t;
  // Operating modes.
  typedef enum logic [2:0] {
    UVP_MODE_ON, UVP_MODE_BLOCKED, UVP_MODE_TEST, UVP_MODE_TESTBLK,
    UVP_MODE_OFF
  } uvp_mode_t;
  // Forced status.
  typedef enum logic [1:0] {
    UVP_F_NORMAL, UVP_F_START, UVP_F_TRIP, UVP_F_BLOCKED
  } uvp_force_t;
endpackage

// >>> dv/uvp_top_asserts.sv
// Checker of bus answers and stage output timing of the undervoltage block.
`timescale 1ns/10ps
module uvp_top_asserts #(
  parameter int TICK_CYC = uvp_pkg::REFRESH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] start_o,
  input wire logic [3:0] trip_o,
  input wire logic [3:0] blocked_o
);
  // Mirror of the refresh time base, restarted by every reset.
  logic [18:0] cnt_q;
  // High when the address hits a register of the map.
  wire logic map_ok = paddr[1:0] == 2'h0 && (paddr < 12'h008 ||
    (paddr >= 12'h010 && paddr < 12'h050 && paddr[3:2] != 2'h3));
  // Counter wraps after one refresh period of cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 19'h00000;
    end else begin
      cnt_q <= (cnt_q == 19'(TICK_CYC - 1)) ? 19'h00000 : cnt_q + 19'h00001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access phase of the bus.
  sequence s_acc;
    psel && penable;
  endsequence
  chk_ready_nowait: assert property (s_acc |-> pready)
    else $error("pready low in access phase");
  chk_err_unmapped: assert property (s_acc and !map_ok |-> pslverr)
    else $error("no error for unmapped access");
  chk_err_mapped: assert property (s_acc and map_ok |-> !pslverr)
    else $error("error for mapped access");
  chk_reset_quiet: assert property (!$past(presetn) |->
    {start_o, trip_o, blocked_o} == 12'h000)
    else $error("outputs active right after reset");
  chk_reset_quiet2: assert property (!$past(presetn, 2) |->
    {start_o, trip_o, blocked_o} == 12'h000)
    else $error("outputs active two cycles after reset");
  chk_tick_align: assert property ($changed({start_o, trip_o, blocked_o})
    |-> cnt_q < 19'h00003 || cnt_q > 19'(TICK_CYC - 4))
    else $error("outputs changed away from refresh tick");
  chk_trip_start: assert property ((trip_o & ~start_o) == 4'h0)
    else $error("trip without start");
  chk_start_blk: assert property ((start_o & blocked_o) == 4'h0)
    else $error("start and blocked together");
endmodule
bind uvp_top uvp_top_asserts #(.TICK_CYC(TICK_CYC)) uvp_top_asserts_inst (
  .pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .start_o(start_o),
  .trip_o(trip_o), .blocked_o(blocked_o));

// >>> dv/uvp_meas_model.sv
// Model of the measurement channels and the external blocking matrix.
`timescale 1ns/10ps
module uvp_meas_model (
  input wire logic [15:0] v_pp0,
  input wire logic [15:0] v_pp2,
  input wire logic [15:0] v_pe,
  input wire logic [15:0] v_c3,
  input wire logic [15:0] v_c4,
  input wire logic [3:0] v_ext,
  output logic [15:0] m_pp0,
  output logic [15:0] m_pp1,
  output logic [15:0] m_pp2,
  output logic [15:0] m_pe0,
  output logic [15:0] m_pe1,
  output logic [15:0] m_pe2,
  output logic [15:0] m_c3,
  output logic [15:0] m_c4,
  output logic [3:0] m_ext
);
  // Magnitudes follow the bench inputs directly; the middle line stays high.
  assign m_pp0 = v_pp0;
  assign m_pp1 = 16'h2710;
  assign m_pp2 = v_pp2;
  assign m_pe0 = v_pe;
  assign m_pe1 = v_pe;
  assign m_pe2 = v_pe;
  assign m_c3 = v_c3;
  assign m_c4 = v_c4;
  // Blocking matrix is a plain level, one per stage.
  assign m_ext = v_ext;
endmodule

// >>> dv/uvp_top_bench.sv
// Self-checking bench of the four undervoltage stages.
`timescale 1ns/10ps
module uvp_top_bench;
  localparam logic [15:0] HI = 16'h2710;
  localparam logic [15:0] LO = 16'h1388;
  // Refresh period of the bench build, short to keep the run brief.
  localparam int TICK = 250;
  // One row: two-line flag, magnitudes, block, expected outputs.
  typedef struct packed {
    logic tl;
    logic [15:0] p0, p2, pe, c3, c4;
    logic [3:0] ex, st, tr, bl;
  } uvp_row_t;
  // State carries from row to row, so the order matters.
  uvp_row_t rows [6] = '{
    '{1'b0, HI, HI, HI, HI, HI, 4'h0, 4'h0, 4'h0, 4'h0},
    '{1'b0, LO, HI, 16'h176F, LO, 16'h176F, 4'h0, 4'hB, 4'hB, 4'h0},
    '{1'b0, 16'h17D4, HI, 16'h1824, HI, 16'h1825, 4'h0, 4'h3, 4'h3, 4'h0},
    '{1'b1, 16'h01F4, HI, HI, LO, HI, 4'h0, 4'h5, 4'h4, 4'h0},
    '{1'b1, LO, LO, HI, HI, HI, 4'h0, 4'h1, 4'h0, 4'h0},
    '{1'b1, HI, HI, HI, HI, LO, 4'h8, 4'h0, 4'h0, 4'h8}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] v_pp0 = HI, v_pp2 = HI, v_pe = HI, v_c3 = HI, v_c4 = HI;
  logic [15:0] m_pp0, m_pp1, m_pp2, m_pe0, m_pe1, m_pe2, m_c3, m_c4;
  logic [3:0] v_ext = 4'h0, m_ext, start_o, trip_o, blocked_o;
  int errors = 0;
  int samples_checked = 0;
  uvp_meas_model uvp_meas_model_inst (.v_pp0(v_pp0), .v_pp2(v_pp2),
    .v_pe(v_pe), .v_c3(v_c3), .v_c4(v_c4), .v_ext(v_ext),
    .m_pp0(m_pp0), .m_pp1(m_pp1), .m_pp2(m_pp2), .m_pe0(m_pe0),
    .m_pe1(m_pe1), .m_pe2(m_pe2), .m_c3(m_c3), .m_c4(m_c4),
    .m_ext(m_ext));
  uvp_top #(.TICK_CYC(TICK)) uvp_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mag_pp0(m_pp0), .mag_pp1(m_pp1), .mag_pp2(m_pp2), .mag_pe0(m_pe0),
    .mag_pe1(m_pe1), .mag_pe2(m_pe2), .third_voltage_input(m_c3),
    .fourth_voltage_input(m_c4), .ext_block(m_ext), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o));
  // Clock of 10 ns period.
  initial begin
    forever #5 pclk = ~pclk;
  end
  // One bus transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits out two refresh ticks, long enough for any change to show.
  task automatic settle();
    repeat (2 * TICK + 10) @(posedge pclk);
  endtask
  // Case-equal comparison, so an unknown never matches.
  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // A clean run takes about 5200 cycles; this allows over three times that.
  initial begin
    #200_000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Stage n watches selection n and trips at once.
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, 12'h010 + 12'(16 * n), 32'h1000 | 32'(n) << 8);
    end
    foreach (rows[i]) begin
      apb(1'b1, uvp_pkg::GLOBAL_OFS, 32'(rows[i].tl) << 2);
      v_pp0 <= rows[i].p0;
      v_pp2 <= rows[i].p2;
      v_pe <= rows[i].pe;
      v_c3 <= rows[i].c3;
      v_c4 <= rows[i].c4;
      v_ext <= rows[i].ex;
      // Outputs answer at the second refresh tick after a change.
      settle();
      cmp("start", 32'(rows[i].st), 32'(start_o));
      cmp("trip", 32'(rows[i].tr), 32'(trip_o));
      cmp("blocked", 32'(rows[i].bl), 32'(blocked_o));
    end
    // Forcing overrides stages 0 to 2 only while the global enable is set.
    apb(1'b1, uvp_pkg::GLOBAL_OFS, 32'h0000_0006);
    apb(1'b1, 12'h010, 32'h0000_1020);
    apb(1'b1, 12'h020, 32'h0000_1110);
    apb(1'b1, 12'h030, 32'h0000_1230);
    apb(1'b1, 12'h040, 32'h0000_1300);
    settle();
    cmp("start", 32'h3, 32'(start_o));
    cmp("trip", 32'h1, 32'(trip_o));
    cmp("blocked", 32'hC, 32'(blocked_o));
    apb(1'b1, uvp_pkg::GLOBAL_OFS, 32'h0000_0004);
    settle();
    cmp("start", 32'h0, 32'(start_o));
    cmp("trip", 32'h0, 32'(trip_o));
    cmp("blocked", 32'h8, 32'(blocked_o));
    // Test/blocked, blocked, off and test modes, set while allowed.
    apb(1'b1, uvp_pkg::GLOBAL_OFS, 32'h0000_0005);
    apb(1'b1, 12'h010, 32'h0000_1003);
    apb(1'b1, 12'h020, 32'h0000_1101);
    apb(1'b1, 12'h030, 32'h0000_1204);
    apb(1'b1, 12'h040, 32'h0000_1302);
    v_pp0 <= LO;
    v_pe <= LO;
    v_c3 <= LO;
    v_ext <= 4'h0;
    settle();
    cmp("start", 32'h8, 32'(start_o));
    cmp("trip", 32'h8, 32'(trip_o));
    cmp("blocked", 32'h3, 32'(blocked_o));
    // A zero block level lets stage 0 trip on a near-dead line.
    apb(1'b1, 12'h014, 32'h0000_1770);
    apb(1'b1, 12'h010, 32'h0000_1000);
    apb(1'b1, 12'h020, 32'h0000_1100);
    v_pp0 <= 16'h01F4;
    v_pe <= 16'h01F4;
    settle();
    cmp("start", 32'hB, 32'(start_o));
    cmp("trip", 32'h9, 32'(trip_o));
    cmp("blocked", 32'h0, 32'(blocked_o));
    apb(1'b0, 12'h028, 32'h0);
    cmp("status", 32'h31, rd);
    apb(1'b0, uvp_pkg::CHAN_OFS, 32'h0);
    cmp("channels", 32'h1388_1388, rd);
    cmp("slverr", 32'h0, 32'(er));
    // A second reset in mid-run restores the defaults.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp("blocked", 32'h0, 32'(blocked_o));
    cmp("start", 32'h0, 32'(start_o));
    cmp("trip", 32'h0, 32'(trip_o));
    apb(1'b0, 12'h014, 32'h0);
    cmp("level", 32'h03E8_1770, rd);
    apb(1'b0, 12'h010, 32'h0);
    cmp("ctrl", 32'h0000_0000, rd);
    // Mode field is locked until the global allow bit is set.
    apb(1'b1, 12'h010, 32'h0000_1004);
    apb(1'b0, 12'h010, 32'h0);
    cmp("ctrl", 32'h0000_1000, rd);
    apb(1'b1, uvp_pkg::GLOBAL_OFS, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_1004);
    apb(1'b0, 12'h010, 32'h0);
    cmp("ctrl", 32'h0000_1004, rd);
    // Space beyond the fourth stage is not mapped.
    apb(1'b0, 12'h050, 32'h0);
    cmp("slverr", 32'h1, 32'(er));
    print_verdict();
  end
endmodule
